// ### verilog/mdc_pkg.sv
package mdc_pkg;

    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_RECIRC = 4'h7;
    localparam logic [3:0] IDX_BUCK   = 4'h8;
    localparam logic [3:0] IDX_MOTION = 4'h9;
    localparam logic [3:0] IDX_LOCK   = 4'hA;

    localparam logic [7:0] RST_RECIRC = 8'h00;
    localparam logic [7:0] RST_BUCK   = 8'h00;
    localparam logic [7:0] RST_MOTION = 8'h00;
    localparam logic [7:0] RST_LOCK   = 8'h00;

    // writable bits; read-only reserved bits are cleared by these masks
    localparam logic [7:0] WMASK_RECIRC = 8'hFF;
    localparam logic [7:0] WMASK_BUCK   = 8'h3F;
    localparam logic [7:0] WMASK_MOTION = 8'h1F;
    localparam logic [7:0] WMASK_LOCK   = 8'hDF;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;

    typedef struct packed {
        logic       rsv7;
        logic       limit_recirc_path_sel;
        logic [1:0] rsv5_4;
        logic       async_rect_active_en;
        logic       sync_rect_active_en;
        logic [1:0] sense_amp_gain_sel;
    } mdc_recirc_s;

    typedef struct packed {
        logic [1:0] rsv7_6;
        logic       rsv5;
        logic       regulator_sequencing_off;
        logic       regulator_limit_sel;
        logic [1:0] regulator_voltage_sel;
        logic       regulator_off;
    } mdc_buck_s;

    typedef struct packed {
        logic [2:0] rsv7_5;
        logic       position_comparator_hysteresis;
        logic       brake_response_sel;
        logic       coast_cmd;
        logic       brake_cmd;
        logic       rotation_dir;
    } mdc_motion_s;

    typedef enum logic [1:0] {
        DRV_RUN,
        DRV_BRAKE,
        DRV_COAST
    } mdc_drive_e;

    // decoded analog settings for the sense, regulator and comparator trims
    typedef struct packed {
        logic [10:0] gain_mv_per_a;
        logic [12:0] buck_mv;
        logic [9:0]  buck_limit_ma;
        logic [5:0]  hys_mv;
    } mdc_trim_s;

    localparam logic [10:0] GAIN_MV_0 = 11'h096;
    localparam logic [10:0] GAIN_MV_1 = 11'h12C;
    localparam logic [10:0] GAIN_MV_2 = 11'h258;
    localparam logic [10:0] GAIN_MV_3 = 11'h4B0;
    localparam logic [12:0] BUCK_MV_0 = 13'h0CE4;
    localparam logic [12:0] BUCK_MV_1 = 13'h1388;
    localparam logic [12:0] BUCK_MV_2 = 13'h0FA0;
    localparam logic [12:0] BUCK_MV_3 = 13'h1644;
    localparam logic [9:0]  BUCK_MA_HI = 10'h258;
    localparam logic [9:0]  BUCK_MA_LO = 10'h096;
    localparam logic [5:0]  HYS_MV_LO  = 6'h05;
    localparam logic [5:0]  HYS_MV_HI  = 6'h32;

    function automatic logic [3:0] addr_index(input logic [11:0] addr);
        addr_index = addr[5:2];
    endfunction

    function automatic logic addr_hit(input logic [11:0] addr);
        logic [3:0] idx;
        idx = addr_index(addr);
        addr_hit = (addr[1:0] == 2'h0) && (addr[11:6] == 6'h00)
                   && (idx >= IDX_RECIRC) && (idx <= IDX_LOCK);
    endfunction

endpackage

// ### verilog/mdc_apb_slave.sv
`timescale 1ns/1ns
`default_nettype none
module mdc_apb_slave
    import mdc_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [3:0]        pstrb,
    input  wire logic [REG_W-1:0]  rd_value,
    output logic                   pready,
    output logic [DATA_W-1:0]      prdata,
    output logic                   pslverr,
    output logic                   wr_pulse
);
    logic setup;
    logic hit;

    assign setup = psel & ~penable;
    assign hit   = addr_hit(paddr);

    // zero wait states: ready is raised by the setup edge, held one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup & ~hit;
        end
    end

    // read data is captured at setup; only this master can write meanwhile
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup && !pwrite && hit) begin
            prdata <= {{(DATA_W-REG_W){1'b0}}, rd_value};
        end else if (setup) begin
            prdata <= '0;
        end
    end

    // narrow registers sit in byte lane 0, so only that strobe matters
    assign wr_pulse = psel & penable & pready & pwrite & hit & pstrb[0];
endmodule
`default_nettype wire

// ### verilog/mdc_drive_state.sv
`timescale 1ns/1ns
`default_nettype none
module mdc_drive_state
    import mdc_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   brake_cmd,
    input  wire logic   coast_cmd,
    input  wire logic   brake_response_sel,
    output mdc_drive_e  drive_action
);
    mdc_drive_e action_d;

    // coast wins when both commands are set: releasing the bridge is safest
    always_comb begin
        action_d = DRV_RUN;
        if (coast_cmd) begin
            action_d = DRV_COAST;
        // [R10] brake style choice
        end else if (brake_cmd && brake_response_sel) begin
            action_d = DRV_COAST;
        end else if (brake_cmd) begin
            action_d = DRV_BRAKE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_action <= DRV_RUN;
        end else begin
            drive_action <= action_d;
        end
    end
endmodule
`default_nettype wire

// ### verilog/mdc_ctrl_regs.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Operation
// [R1] bit 6 at 7h: 0 recirculates through transistors, 1 through diodes
// [R2] bit 3 at 7h enables active asynchronous rectification
// [R3] bit 2 at 7h enables active synchronous rectification
// [R4] bits 1-0 at 7h pick sense gain 0.15, 0.3, 0.6, 1.2 V/A
// [R5] bit 4 at 8h set turns regulator power sequencing off
// [R6] bit 3 at 8h: regulator current limit 600 mA or 150 mA
// [R7] bits 2-1 at 8h pick regulator 3.3, 5.0, 4.0, 5.7 V
// [R8] bit 0 at 8h set switches the regulator off
// [R9] bit 4 at 9h: comparator hysteresis 5 mV or 50 mV
// [R10] bit 3 at 9h: brake request brakes when 0, coasts when 1
// [R11] bit 2 at 9h commands coast while set
// [R12] bit 1 at 9h commands brake while set
// [R13] bit 0 at 9h: direction clockwise when 0, anti-clockwise when 1
// [R14] all four registers reset to 00h
// [R15] read-only reserved bits read zero; writable reserved bits just store
module mdc_ctrl_regs
    import mdc_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [DATA_W-1:0]  pwdata,
    input  wire logic [3:0]         pstrb,
    output logic                    pready,
    output logic [DATA_W-1:0]       prdata,
    output logic                    pslverr,
    output logic                    limit_recirc_path_sel,
    output logic                    async_rect_active_en,
    output logic                    sync_rect_active_en,
    output logic [1:0]              sense_amp_gain_sel,
    output logic                    regulator_sequencing_off,
    output logic                    regulator_limit_sel,
    output logic [1:0]              regulator_voltage_sel,
    output logic                    regulator_off,
    output logic                    position_comparator_hysteresis,
    output logic                    rotation_dir,
    output mdc_drive_e              drive_action,
    output mdc_trim_s               trim_values,
    output logic [REG_W-1:0]        lock_protect_cfg
);
    mdc_recirc_s       recirc_q;
    mdc_buck_s         buck_q;
    mdc_motion_s       motion_q;
    logic [REG_W-1:0]  lock_q;
    logic [REG_W-1:0]  rd_value;
    logic [REG_W-1:0]  wbyte;
    logic [3:0]        wr_idx;
    logic              wr_pulse;
    mdc_trim_s         trim_d;

    assign wbyte  = pwdata[REG_W-1:0];
    assign wr_idx = addr_index(paddr);

    mdc_apb_slave u_apb (
        .pclk     (pclk),
        .presetn  (presetn),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pstrb    (pstrb),
        .rd_value (rd_value),
        .pready   (pready),
        .prdata   (prdata),
        .pslverr  (pslverr),
        .wr_pulse (wr_pulse)
    );

    // [R14] reset to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recirc_q <= mdc_recirc_s'(RST_RECIRC);
        end else if (wr_pulse && wr_idx == IDX_RECIRC) begin
            recirc_q <= mdc_recirc_s'(wbyte & WMASK_RECIRC);
        end
    end

    // [R15] masked reserved bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buck_q <= mdc_buck_s'(RST_BUCK);
        end else if (wr_pulse && wr_idx == IDX_BUCK) begin
            buck_q <= mdc_buck_s'(wbyte & WMASK_BUCK);
        end
    end

    // [R15] masked reserved bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motion_q <= mdc_motion_s'(RST_MOTION);
        end else if (wr_pulse && wr_idx == IDX_MOTION) begin
            motion_q <= mdc_motion_s'(wbyte & WMASK_MOTION);
        end
    end

    // [R14] reset to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= RST_LOCK;
        end else if (wr_pulse && wr_idx == IDX_LOCK) begin
            lock_q <= wbyte & WMASK_LOCK;
        end
    end

    always_comb begin
        if (wr_idx == IDX_RECIRC) begin
            rd_value = recirc_q;
        end else if (wr_idx == IDX_BUCK) begin
            rd_value = buck_q;
        end else if (wr_idx == IDX_MOTION) begin
            rd_value = motion_q;
        end else if (wr_idx == IDX_LOCK) begin
            rd_value = lock_q;
        end else begin
            rd_value = '0;
        end
    end

    // control outputs follow the registers one cycle later, from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_recirc_path_sel <= 1'b0;
            async_rect_active_en  <= 1'b0;
            sync_rect_active_en   <= 1'b0;
            sense_amp_gain_sel    <= 2'h0;
        end else begin
            // [R1] recirculation path
            limit_recirc_path_sel <= recirc_q.limit_recirc_path_sel;
            // [R2] async rectification enable
            async_rect_active_en  <= recirc_q.async_rect_active_en;
            // [R3] sync rectification enable
            sync_rect_active_en   <= recirc_q.sync_rect_active_en;
            // [R4] sense gain select
            sense_amp_gain_sel    <= recirc_q.sense_amp_gain_sel;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regulator_sequencing_off <= 1'b0;
            regulator_limit_sel      <= 1'b0;
            regulator_voltage_sel    <= 2'h0;
            regulator_off            <= 1'b0;
        end else begin
            // [R5] sequencing off
            regulator_sequencing_off <= buck_q.regulator_sequencing_off;
            // [R6] current limit select
            regulator_limit_sel      <= buck_q.regulator_limit_sel;
            // [R7] output voltage select
            regulator_voltage_sel    <= buck_q.regulator_voltage_sel;
            // [R8] regulator off
            regulator_off            <= buck_q.regulator_off;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position_comparator_hysteresis <= 1'b0;
            rotation_dir                   <= 1'b0;
            lock_protect_cfg               <= RST_LOCK;
        end else begin
            // [R9] hysteresis select
            position_comparator_hysteresis <= motion_q.position_comparator_hysteresis;
            // [R13] rotation direction
            rotation_dir                   <= motion_q.rotation_dir;
            lock_protect_cfg               <= lock_q;
        end
    end

    // [R11] [R12] coast and brake commands
    mdc_drive_state u_drive (
        .pclk               (pclk),
        .presetn            (presetn),
        .brake_cmd          (motion_q.brake_cmd),
        .coast_cmd          (motion_q.coast_cmd),
        .brake_response_sel (motion_q.brake_response_sel),
        .drive_action       (drive_action)
    );

    always_comb begin
        // [R4] gain in mV per A
        case (recirc_q.sense_amp_gain_sel)
            2'h0: trim_d.gain_mv_per_a = GAIN_MV_0;
            2'h1: trim_d.gain_mv_per_a = GAIN_MV_1;
            2'h2: trim_d.gain_mv_per_a = GAIN_MV_2;
            default: trim_d.gain_mv_per_a = GAIN_MV_3;
        endcase
        // [R7] regulator output in mV
        case (buck_q.regulator_voltage_sel)
            2'h0: trim_d.buck_mv = BUCK_MV_0;
            2'h1: trim_d.buck_mv = BUCK_MV_1;
            2'h2: trim_d.buck_mv = BUCK_MV_2;
            default: trim_d.buck_mv = BUCK_MV_3;
        endcase
        // [R6] limit in mA
        trim_d.buck_limit_ma = buck_q.regulator_limit_sel ? BUCK_MA_LO : BUCK_MA_HI;
        // [R9] hysteresis in mV
        trim_d.hys_mv = motion_q.position_comparator_hysteresis ? HYS_MV_HI : HYS_MV_LO;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_values <= '{GAIN_MV_0, BUCK_MV_0, BUCK_MA_HI, HYS_MV_LO};
        end else begin
            trim_values <= trim_d;
        end
    end
endmodule
`default_nettype wire

// ### test/mdc_ctrl_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module mdc_ctrl_regs_chk
    import mdc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    input  wire logic [1:0]  sense_amp_gain_sel,
    input  wire logic        regulator_off,
    input  wire logic        position_comparator_hysteresis,
    input  wire logic        rotation_dir,
    input  wire mdc_drive_e  drive_action,
    input  wire mdc_trim_s   trim_values
);
    logic setup;
    logic bad;
    logic wr;
    assign setup = psel && !penable;
    assign bad = paddr[11:6] != 6'h00 || paddr[1:0] != 2'h0
                 || paddr[5:2] < 4'h7 || paddr[5:2] > 4'hA;
    assign wr = psel && penable && pready && pwrite && pstrb[0];

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_err_unmapped: assert property (setup && bad
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (setup && !bad
        |=> !pslverr && prdata[31:8] == 24'h0)
        else $error("mapped access flagged or upper bits set");
    // outputs follow the register one edge after the write edge
    a_gain_write: assert property (wr && paddr == 12'h01C
        |-> ##2 sense_amp_gain_sel == $past(pwdata[1:0], 2))
        else $error("gain select not taken from write");
    a_off_write: assert property (wr && paddr == 12'h020
        |-> ##2 regulator_off == $past(pwdata[0], 2))
        else $error("regulator off not taken from write");
    a_hyst_write: assert property (wr && paddr == 12'h024
        |-> ##2 position_comparator_hysteresis == $past(pwdata[4], 2))
        else $error("hysteresis not taken from write");
    a_dir_write: assert property (wr && paddr == 12'h024
        |-> ##2 rotation_dir == $past(pwdata[0], 2))
        else $error("direction not taken from write");
    a_coast_write: assert property (wr && paddr == 12'h024 && pwdata[2]
        |-> ##2 drive_action == DRV_COAST)
        else $error("coast command not obeyed");
    a_hyst_trim: assert property (trim_values.hys_mv ==
        (position_comparator_hysteresis ? 6'h32 : 6'h05))
        else $error("hysteresis figure wrong");
    a_gain_trim: assert property (sense_amp_gain_sel == 2'h3
        |-> trim_values.gain_mv_per_a == 11'h4B0)
        else $error("top gain figure wrong");

    c_coast: cover property (wr && paddr == 12'h024 && pwdata[2]);
    c_err: cover property (pready && pslverr);
    c_brake: cover property (drive_action == DRV_BRAKE);
endmodule

bind mdc_ctrl_regs mdc_ctrl_regs_chk chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sense_amp_gain_sel(sense_amp_gain_sel),
    .regulator_off(regulator_off),
    .position_comparator_hysteresis(position_comparator_hysteresis),
    .rotation_dir(rotation_dir), .drive_action(drive_action), .trim_values(trim_values)
);
`default_nettype wire

// ### test/tb_mdc_ctrl_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tb_mdc_ctrl_regs import mdc_pkg::*;;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        pready, pslverr, lrp, are, sre, rso, rls, roff, pch, rdir;
    logic [1:0]  gain, vsel;
    logic [7:0]  lock;
    mdc_drive_e  drv;
    mdc_trim_s   trim;
    logic [7:0]  mem [4];
    logic [7:0]  wm [4];
    int          n_errors = 0;
    int          n_checks = 0;
    int          gmv [4] = '{150, 300, 600, 1200};
    int          bmv [4] = '{3300, 5000, 4000, 5700};

    always #2 pclk = ~pclk;

    mdc_ctrl_regs dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .limit_recirc_path_sel(lrp), .async_rect_active_en(are),
        .sync_rect_active_en(sre), .sense_amp_gain_sel(gain),
        .regulator_sequencing_off(rso), .regulator_limit_sel(rls),
        .regulator_voltage_sel(vsel), .regulator_off(roff),
        .position_comparator_hysteresis(pch), .rotation_dir(rdir),
        .drive_action(drv), .trim_values(trim), .lock_protect_cfg(lock)
    );

    task automatic chk(input logic ok, input string m);
        n_checks++;
        // an unknown result must count as a mismatch, not slip through
        if (ok !== 1'b1) begin
            n_errors++;
            $display("Error %0t %s", $time, m);
        end
    endtask

    task automatic end_sim();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one apb transfer; the bench model is updated at the edge the write lands
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        int   k;
        logic bad;
        bad = a[11:6] != 6'h00 || a[1:0] != 2'h0 || a[5:2] < 4'h7 || a[5:2] > 4'hA;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk(k < 20, "no ready");
        chk(pslverr === bad, "error flag");
        if (!w) chk(prdata === (bad ? 32'h0 : {24'h0, mem[a[5:2] - 4'h7]}), "read data");
        if (w && !bad && s[0]) mem[a[5:2] - 4'h7] = d[7:0] & wm[a[5:2] - 4'h7];
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic outs();
        logic [7:0] r, b, m;
        mdc_drive_e e;
        r = mem[0];
        b = mem[1];
        m = mem[2];
        // coast command wins over brake
        e = m[2] ? DRV_COAST : (m[1] ? (m[3] ? DRV_COAST : DRV_BRAKE) : DRV_RUN);
        chk(lrp === r[6], "recirc path");
        chk(are === r[3] && sre === r[2], "rectification");
        chk(gain === r[1:0] && trim.gain_mv_per_a === 11'(gmv[r[1:0]]), "gain");
        chk(rso === b[4], "sequencing");
        chk(rls === b[3] && trim.buck_limit_ma === (b[3] ? 10'h096 : 10'h258), "limit");
        chk(vsel === b[2:1] && trim.buck_mv === 13'(bmv[b[2:1]]), "voltage");
        chk(roff === b[0], "regulator off");
        chk(pch === m[4] && trim.hys_mv === (m[4] ? 6'h32 : 6'h05), "hysteresis");
        chk(drv === e, "drive action");
        chk(rdir === m[0], "direction");
        chk(lock === mem[3], "lock byte");
    endtask

    initial begin
        int          i;
        logic [31:0] d;
        logic [3:0]  s;
        logic [11:0] badl [5];
        badl = '{12'h000, 12'h018, 12'h02C, 12'h01E, 12'h41C};
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        wm = '{WMASK_RECIRC, WMASK_BUCK, WMASK_MOTION, WMASK_LOCK};
        mem = '{default: 8'h00};
        void'($urandom(12800));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        outs();
        for (i = 0; i < 4; i++) xfer(1'b0, 12'h01C + 12'(4 * i), 32'h0, 4'h0);
        // random data and strobes; a clear lane-0 strobe must leave the register alone
        repeat (80) begin
            i = $urandom_range(3, 0);
            d = $urandom;
            s = 4'($urandom);
            xfer(1'b1, 12'h01C + 12'(4 * i), d, s);
            @(posedge pclk);
            outs();
            xfer(1'b0, 12'h01C + 12'(4 * i), 32'h0, 4'hF);
        end
        foreach (badl[j]) begin
            xfer(1'b1, badl[j], 32'hFFFF_FFFF, 4'hF);
            xfer(1'b0, badl[j], 32'h0, 4'hF);
        end
        @(posedge pclk);
        outs();
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        mem = '{default: 8'h00};
        @(posedge pclk);
        outs();
        // registers hold random values before this reset, so zero read-back proves it
        for (i = 0; i < 4; i++) xfer(1'b0, 12'h01C + 12'(4 * i), 32'h0, 4'hF);
        end_sim();
    end

    // the sequence needs about 640 cycles; allow a wide margin
    initial begin
        #40000;
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
